// file: logic/pm_event_consts.vh
// constants for the power mode and event manager
`ifndef PM_EVENT_CONSTS_VH
`define PM_EVENT_CONSTS_VH
`define EVT_RESP_CODE 8'h08
`define CMD_SLEEP 8'h03
`define WAKE_BYTE 8'h00
`define ACK_CODE 8'h00
`define START_CODE 8'h01
`define BIT_POLL 6
`define BIT_CMD_END 5
`define BIT_CMP 4
`define OFF_DESC 8'h01
`define OFF_UID 8'h02
`define UID_MAX 4'ha
`define STARTUP_NS 1000
`define CLK_NS 50
`define STARTUP_CYC ((`STARTUP_NS + `CLK_NS - 1) / `CLK_NS)
`define A_CTRL 4'h0
`define A_STAT 4'h1
`define A_IRQ 4'h2
`define A_MASK 4'h3
`define A_TAG 4'h4
`define A_UID 4'h5
`define CTRL_RST 8'h7f
`endif

// file: logic/power_mode_event_manager.v
// power mode sequencer and asynchronous event packet formatter
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "pm_event_consts.vh"
module power_mode_event_manager
(
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire power_down_request_n,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire link_busy,
  input wire cmd_busy,
  input wire cmd_end,
  input wire poll_event,
  input wire cmp_change,
  input wire [3:0] line_edge,
  output reg [7:0] tx_data,
  output reg tx_valid,
  input wire tx_ready,
  output reg low_power_indicator_n,
  output reg comm_enable,
  output reg pwm_enable,
  output reg analog_enable,
  output reg lines_hiz,
  output reg defaults_restore,
  output reg volatile_clear,
  output wire irq
);
  localparam ST_RUN = 6'b000001;
  localparam ST_SLEEP = 6'b000010;
  localparam ST_PREP = 6'b000100;
  localparam ST_DOWN = 6'b001000;
  localparam ST_START = 6'b010000;
  localparam ST_WAKE = 6'b100000;
  localparam TX_IDLE = 4'b0001;
  localparam TX_CODE = 4'b0010;
  localparam TX_BODY = 4'b0100;
  localparam TX_DONE = 4'b1000;
  localparam integer START_INT = `STARTUP_CYC;
  localparam [15:0] START_CYC = START_INT[15:0];

  reg [5:0] state;
  reg [3:0] txs;
  reg [7:0] ctrl;
  reg [3:0] irq_stat;
  reg [3:0] irq_mask;
  reg [7:0] tag_desc;
  reg [3:0] tag_len;
  reg [7:0] uid [0:9];
  reg [6:0] pend;
  reg [7:0] flags;
  reg [7:0] code;
  reg [3:0] idx;
  reg [3:0] body_len;
  reg [15:0] cnt;
  reg first_clk;
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg ack_req;
  reg start_req;
  reg sleep_after;
  wire [7:0] next_tx;
  reg [3:0] ev_set;
  wire [6:0] new_ev;
  wire wr_go;
  wire tx_free;
  integer i;

  function [7:0] merge;
    input [7:0] old;
    input [31:0] d;
    input s;
    begin
      merge = s ? d[7:0] : old;
    end
  endfunction

  // ctrl[3:0] line enables, [4] comparator, [6] polling
  assign new_ev = {poll_event & ctrl[`BIT_POLL], cmd_end,
    cmp_change & ctrl[`BIT_CMP], line_edge & ctrl[3:0]};
  assign tx_free = (txs == TX_IDLE);
  assign wr_go = aw_held & w_held & ~s_axi_bvalid;
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;
  assign irq = |(irq_stat & irq_mask);
  assign next_tx = (idx == `OFF_DESC) ? tag_desc : uid[idx - 4'h2];

  always @*
  begin
    ev_set = 4'h0;
    if (txs == TX_DONE && tx_ready)
    begin
      if (code == `EVT_RESP_CODE)
        ev_set[0] = 1'b1;
      else if (body_len == 4'h1)
        ev_set[2] = 1'b1;
      else
        ev_set[1] = 1'b1;
    end
    if (state == ST_DOWN)
      ev_set[3] = 1'b1;
  end

  // bus slave; volatile registers cleared on power-down restart
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0;
      ctrl <= `CTRL_RST;
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      tag_desc <= 8'h00;
      tag_len <= 4'h0;
      for (i = 0; i < 10; i = i + 1)
        uid[i] <= 8'h00;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // set wins over a write-one clear
      irq_stat <= irq_stat | ev_set;
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (aw_addr[3:2])
          2'b00: ctrl <= merge(ctrl, w_data, w_strb[0]);
          2'b01: irq_mask <= w_strb[0] ? w_data[3:0] : irq_mask;
          2'b10:
          begin
            tag_desc <= merge(tag_desc, w_data, w_strb[0]);
            if (w_strb[1])
              tag_len <= (w_data[11:8] > `UID_MAX) ? `UID_MAX : w_data[11:8];
          end
          default:
          begin
            if (w_data[7:0] == 8'h00 && w_strb[0])
              irq_stat <= (irq_stat & ~w_data[11:8]) | ev_set;
            else if (w_strb[0] && w_data[7:0] < 8'h0a)
              uid[w_data[3:0]] <= w_data[15:8];
            else
              s_axi_bresp <= 2'b10;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr[3:2])
          2'b00: s_axi_rdata <= {24'h0, ctrl};
          2'b01: s_axi_rdata <= {16'h0, irq_stat, irq_mask, 2'b00, state};
          2'b10: s_axi_rdata <= {20'h0, tag_len, tag_desc};
          default: s_axi_rdata <= {24'h0, pend, 1'b0};
        endcase
      end
      if (volatile_clear)
      begin
        ctrl <= `CTRL_RST;
        tag_desc <= 8'h00;
        tag_len <= 4'h0;
        for (i = 0; i < 10; i = i + 1)
          uid[i] <= 8'h00;
      end
    end
  end

  // power sequencer and packet transmitter
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_RUN;
      txs <= TX_IDLE;
      pend <= 7'h00;
      flags <= 8'h00;
      code <= 8'h00;
      idx <= 4'h0;
      body_len <= 4'h0;
      cnt <= 16'h0;
      first_clk <= 1'b1;
      ack_req <= 1'b0;
      start_req <= 1'b0;
      sleep_after <= 1'b0;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      low_power_indicator_n <= 1'b1;
      comm_enable <= 1'b1;
      pwm_enable <= 1'b1;
      analog_enable <= 1'b1;
      lines_hiz <= 1'b0;
      defaults_restore <= 1'b0;
      volatile_clear <= 1'b0;
    end
    else
    begin
      first_clk <= 1'b0;
      defaults_restore <= first_clk & ~power_down_request_n;
      volatile_clear <= 1'b0;
      if (state != ST_DOWN && state != ST_PREP)
        pend <= pend | new_ev;
      case (state)
        ST_RUN:
        begin
          low_power_indicator_n <= 1'b1;
          comm_enable <= 1'b1;
          pwm_enable <= 1'b1;
          if (!power_down_request_n)
            state <= ST_PREP;
          else if (rx_valid && rx_data == `CMD_SLEEP)
          begin
            ack_req <= 1'b1;
            sleep_after <= 1'b1;
          end
          else if (sleep_after && tx_free && !ack_req)
          begin
            sleep_after <= 1'b0;
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP:
        begin
          low_power_indicator_n <= 1'b0;
          comm_enable <= 1'b0;
          pwm_enable <= 1'b0;
          if (!power_down_request_n)
            state <= ST_PREP;
          else if (rx_valid && rx_data == `WAKE_BYTE)
          begin
            ack_req <= 1'b1;
            state <= ST_RUN;
          end
          else if (pend != 7'h00)
            state <= ST_WAKE;
        end
        ST_WAKE:
        begin
          comm_enable <= 1'b1;
          if (pend == 7'h00 && tx_free)
            state <= ST_SLEEP;
        end
        ST_PREP:
        begin
          // the pin is only a request; it is re-checked until idle
          if (power_down_request_n)
            state <= ST_RUN;
          else if (!link_busy && !cmd_busy && tx_free)
          begin
            low_power_indicator_n <= 1'b0;
            state <= ST_DOWN;
          end
        end
        ST_DOWN:
        begin
          comm_enable <= 1'b0;
          pwm_enable <= 1'b0;
          analog_enable <= 1'b0;
          lines_hiz <= 1'b1;
          pend <= 7'h00;
          ack_req <= 1'b0;
          sleep_after <= 1'b0;
          low_power_indicator_n <= 1'b0;
          if (power_down_request_n)
          begin
            volatile_clear <= 1'b1;
            cnt <= 16'h0;
            state <= ST_START;
          end
        end
        ST_START:
        begin
          lines_hiz <= 1'b0;
          analog_enable <= 1'b1;
          comm_enable <= 1'b1;
          cnt <= cnt + 16'h1;
          if (cnt == START_CYC - 16'h1)
          begin
            low_power_indicator_n <= 1'b1;
            start_req <= 1'b1;
            state <= ST_RUN;
          end
        end
        default: state <= ST_RUN;
      endcase
      // packet engine: ack, start, then events
      case (txs)
        TX_IDLE:
        begin
          tx_valid <= 1'b0;
          if (comm_enable && state != ST_PREP && state != ST_DOWN)
          begin
            if (ack_req)
            begin
              ack_req <= 1'b0;
              code <= `ACK_CODE;
              body_len <= 4'h0;
              tx_data <= `ACK_CODE;
              tx_valid <= 1'b1;
              txs <= TX_DONE;
            end
            else if (start_req)
            begin
              start_req <= 1'b0;
              code <= `START_CODE;
              body_len <= 4'h1;
              tx_data <= `START_CODE;
              tx_valid <= 1'b1;
              txs <= TX_DONE;
            end
            else if (pend != 7'h00)
            begin
              flags <= {1'b0, pend};
              pend <= new_ev;
              code <= `EVT_RESP_CODE;
              body_len <= pend[6] ? tag_len + 4'h3 : 4'h1;
              tx_data <= `EVT_RESP_CODE;
              tx_valid <= 1'b1;
              idx <= 4'h0;
              txs <= TX_CODE;
            end
          end
        end
        TX_CODE:
          if (tx_ready)
          begin
            tx_data <= flags;
            txs <= (body_len == 4'h1) ? TX_DONE : TX_BODY;
            idx <= 4'h1;
          end
        TX_BODY:
          if (tx_ready)
          begin
            tx_data <= next_tx;
            idx <= idx + 4'h1;
            if (idx == body_len - 4'h2)
              txs <= TX_DONE;
          end
        TX_DONE:
          if (tx_ready)
          begin
            tx_valid <= 1'b0;
            txs <= TX_IDLE;
          end
        default: txs <= TX_IDLE;
      endcase
    end
  end
endmodule // power_mode_event_manager

// file: verif/host_link_model.sv
// host side of the packet link: takes bytes promptly or with stalls
`timescale 1ns/1ns
module host_link_model
(
  input wire aclk,
  input wire aresetn,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire slow,
  output reg tx_ready
);
  logic [7:0] got[$];
  always @(posedge aclk)
  begin
    if (!aresetn)
      tx_ready <= 1'b0;
    else
      tx_ready <= slow ? ~tx_ready : 1'b1;
    if (aresetn && tx_valid && tx_ready)
      got.push_back(tx_data);
  end
endmodule // host_link_model

// file: verif/power_mode_event_manager_checker.sv
// port assertions for the power mode and event manager
`timescale 1ns/1ns
module pm_port_checker
(
  input wire aclk,
  input wire aresetn,
  input wire power_down_request_n,
  input wire link_busy,
  input wire cmd_busy,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire low_power_indicator_n,
  input wire comm_enable,
  input wire pwm_enable,
  input wire analog_enable,
  input wire lines_hiz,
  input wire defaults_restore,
  input wire volatile_clear
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_tx_byte_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte moved");
  a_down_all_off: assert property (
    lines_hiz |-> !comm_enable && !pwm_enable && !analog_enable
      && !low_power_indicator_n)
    else $error("down but active");
  a_busy_defer: assert property (
    $rose(lines_hiz) |-> $past(!link_busy && !cmd_busy, 2))
    else $error("down while busy");
  a_down_entry: assert property (
    $rose(lines_hiz) |-> $past(power_down_request_n, 2) == 1'b0)
    else $error("down without request");
  a_start_low: assert property (
    $rose(power_down_request_n) && lines_hiz
      |-> !low_power_indicator_n [*8])
    else $error("indicator high early");
  a_start_len: assert property (
    $rose(power_down_request_n) && lines_hiz
      |-> ##[18:22] $rose(low_power_indicator_n))
    else $error("startup length off");
  a_wipe_restart: assert property (
    $rose(power_down_request_n) && lines_hiz |-> ##[0:3] volatile_clear)
    else $error("no volatile clear");
  a_defaults_pin: assert property (
    defaults_restore |-> !$past(power_down_request_n))
    else $error("defaults without pin");
endmodule // pm_port_checker
bind power_mode_event_manager pm_port_checker i_chk (.*);

// file: verif/power_mode_event_manager_test.sv
// bench for the power mode and event manager
`timescale 1ns/1ns
`include "pm_event_consts.vh"
module power_mode_event_manager_test;
  logic aclk = 0, aresetn = 0, power_down_request_n = 1, slow = 0, seen = 0;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, line_edge;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, rx_valid, link_busy, cmd_busy;
  logic [7:0] rx_data, tx_data;
  logic cmd_end, poll_event, cmp_change, tx_valid, tx_ready, irq;
  logic low_power_indicator_n, comm_enable, pwm_enable, analog_enable;
  logic lines_hiz, defaults_restore, volatile_clear;
  logic [7:0] ex[$];
  int mismatches = 0, comparisons = 0;
  always #25 aclk = ~aclk;
  power_mode_event_manager i_dut (.*);
  host_link_model i_host (.aclk(aclk), .aresetn(aresetn), .slow(slow),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  // the pulse lasts one cycle, so latch it for a later look
  always @(posedge aclk)
    if (defaults_restore)
      seen <= 1'b1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic quit(input int n);
    if (n >= 300)
    begin
      chk(n, 0);
      print_verdict();
    end
  endtask
  // ready and answers sampled at the falling edge, so no race with updates
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    logic aw, w, b, ar, r;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= we;
    s_axi_wvalid <= we;
    s_axi_bready <= we;
    s_axi_arvalid <= !we;
    s_axi_rready <= !we;
    do
    begin
      @(negedge aclk);
      {aw, w, b, ar, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid,
        s_axi_arready, s_axi_rvalid};
      if (r)
      begin
        q = s_axi_rdata;
        chk(s_axi_rresp, 2'b00);
      end
      if (b)
        chk(s_axi_bresp, 2'b00);
      @(posedge aclk);
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
      if (b)
        s_axi_bready <= 1'b0;
      if (ar)
        s_axi_arvalid <= 1'b0;
      if (r)
        s_axi_rready <= 1'b0;
      n++;
    end
    while ((s_axi_awvalid || s_axi_wvalid || s_axi_bready || s_axi_arvalid
      || s_axi_rready) && n < 300);
    quit(n);
  endtask
  task automatic ev(input logic [6:0] f);
    @(posedge aclk);
    {poll_event, cmd_end, cmp_change, line_edge} <= f;
    @(posedge aclk);
    {poll_event, cmd_end, cmp_change, line_edge} <= 7'h00;
  endtask
  task automatic rx(input logic [7:0] b);
    @(posedge aclk);
    rx_data <= b;
    rx_valid <= 1'b1;
    @(posedge aclk);
    rx_valid <= 1'b0;
  endtask
  task automatic wl(input logic v);
    int n;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (low_power_indicator_n !== v && n < 300);
    quit(n);
    chk(low_power_indicator_n, v);
  endtask
  // waits at least 30 cycles so that stray bytes show up as well
  task automatic pk();
    int n;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while ((i_host.got.size() < ex.size() || n < 30) && n < 300);
    quit(n);
    chk(i_host.got.size(), ex.size());
    foreach (ex[i])
      if (i < i_host.got.size())
        chk(i_host.got[i], ex[i]);
    ex.delete();
    i_host.got.delete();
  endtask
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 10'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {rx_data, rx_valid, link_busy, cmd_busy, cmd_end} = 11'h000;
    {poll_event, cmp_change, line_edge} = 6'h00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({low_power_indicator_n, lines_hiz, irq}, 3'b100);
    bus(0, 4'h0, 0);
    chk(q, `CTRL_RST);
    bus(1, 4'h8, 32'h444);
    bus(1, 4'hc, 32'h1101);
    bus(1, 4'hc, 32'h2202);
    bus(1, 4'hc, 32'h3303);
    bus(1, 4'h4, 32'h1);
    slow <= 1'b1;
    ev(7'h45);
    ex = {8'h08, 8'h45, 8'h44, 8'h00, 8'h11, 8'h22, 8'h33};
    pk();
    slow <= 1'b0;
    chk(irq, 1'b1);
    bus(1, 4'h4, 32'h0);
    @(negedge aclk);
    chk(irq, 1'b0);
    bus(1, 4'h4, 32'h1);
    bus(1, 4'hc, 32'hf00);
    @(negedge aclk);
    chk(irq, 1'b0);
    $display("end packets");
    for (int b = 0; b < 6; b++)
    begin
      ev(7'h01 << b);
      ex = {8'h08, 8'h01 << b};
      pk();
    end
    bus(1, 4'h0, 32'h0);
    ev(7'h7f);
    ex = {8'h08, 8'h20};
    pk();
    ev(7'h5f);
    pk();
    bus(1, 4'h0, 32'h7f);
    $display("end flags");
    rx(`CMD_SLEEP);
    ex = {`ACK_CODE};
    pk();
    chk(low_power_indicator_n, 1'b0);
    chk({comm_enable, pwm_enable, analog_enable}, 3'b001);
    ev(7'h04);
    ex = {8'h08, 8'h04};
    pk();
    chk(low_power_indicator_n, 1'b0);
    rx(`WAKE_BYTE);
    ex = {`ACK_CODE};
    pk();
    chk({low_power_indicator_n, comm_enable}, 2'b11);
    $display("end sleep");
    bus(1, 4'h0, 32'h12);
    link_busy <= 1'b1;
    power_down_request_n <= 1'b0;
    repeat (20) @(posedge aclk);
    link_busy <= 1'b0;
    cmd_busy <= 1'b1;
    @(negedge aclk);
    chk({lines_hiz, low_power_indicator_n}, 2'b01);
    repeat (20) @(posedge aclk);
    cmd_busy <= 1'b0;
    @(negedge aclk);
    chk({lines_hiz, low_power_indicator_n}, 2'b01);
    wl(1'b0);
    // lines and enables follow the indicator by one cycle
    @(negedge aclk);
    chk({lines_hiz, comm_enable, pwm_enable}, 3'b100);
    rx(`CMD_SLEEP);
    pk();
    @(posedge aclk);
    power_down_request_n <= 1'b1;
    wl(1'b1);
    ex = {`START_CODE};
    pk();
    bus(0, 4'h0, 0);
    chk(q, `CTRL_RST);
    chk(seen, 1'b0);
    $display("end power down");
    @(posedge aclk);
    power_down_request_n <= 1'b0;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    power_down_request_n <= 1'b1;
    wl(1'b1);
    ex = {`START_CODE};
    pk();
    chk(seen, 1'b1);
    $display("end defaults");
    print_verdict();
  end
endmodule // power_mode_event_manager_test
